//--- flash_access_pkg.sv
// Purpose: Shared constants and carriers for the flash access protection controller.
// Assumes: 16-bit register port, 24-bit CPU byte addresses.
// Notes:   Offsets are register word indices on the plain register port.
package flash_access_pkg;
    // Register offsets on the plain register port.
    localparam logic [3:0] OFS_PROG0_WREN   = 4'h0;
    localparam logic [3:0] OFS_PROG1_WREN   = 4'h1;
    localparam logic [3:0] OFS_DATA_WREN    = 4'h2;
    localparam logic [3:0] OFS_PROG_IBADDR  = 4'h3;
    localparam logic [3:0] OFS_PROG_IBDATA  = 4'h4;
    localparam logic [3:0] OFS_DATA_IBADDR  = 4'h5;
    localparam logic [3:0] OFS_DATA_IBDATA  = 4'h6;
    localparam logic [3:0] OFS_PROG_STATUS  = 4'h7;
    localparam logic [3:0] OFS_DATA_STATUS  = 4'h8;
    localparam logic [3:0] OFS_PROT_WORD    = 4'h9;
    localparam logic [3:0] OFS_PROG_CTRL    = 4'ha;
    localparam logic [3:0] OFS_DATA_CTRL    = 4'hb;
    // Address map.
    localparam logic [23:0] PROG0_BASE     = 24'h000000;
    localparam logic [23:0] PROG1_BASE     = 24'h020000;
    localparam logic [23:0] PROG_LAST      = 24'h03ffff;
    localparam logic [23:0] DATA_BASE      = 24'h0d0000;
    localparam logic [23:0] DATA_LAST      = 24'h0d1fff;
    localparam logic [23:0] BOOT_MAX_LAST  = 24'h0077ff;
    localparam int          BOOT_UNIT_LSB  = 11;     // 2048-byte boot units.
    localparam int          PROG_SECT_LSB  = 13;     // 8K-byte sections.
    localparam int          DATA_SECT_LSB  = 9;      // 512-byte sections.
    // Information block addresses.
    localparam logic [7:0]  FUNC_WORD_ADDR = 8'h7e;
    localparam logic [7:0]  PROT_WORD_ADDR = 8'hfe;
    localparam logic [7:0]  IB1_FIRST      = 8'h80;
    // Protection word fields.
    localparam int          WRP_LSB  = 13;
    localparam int          RDP_LSB  = 10;
    localparam int          BOOT_LSB = 1;
    // Control bits.
    localparam int          CTRL_PE  = 0;
    localparam int          CTRL_MER = 1;
    // Status bits.
    localparam int          STAT_BUSY = 0;
    localparam int          STAT_FULL = 1;
    // Reset values.
    localparam logic [15:0] WREN_RESET = 16'h0000;
    localparam logic [15:0] PROT_ERASED = 16'hffff;
    // Length of one program or erase operation in cycles.
    localparam int          OP_CYCLES = 16;

    // Request towards one flash array.
    typedef struct packed {
        logic        valid;
        logic        erase;      // One: erase, zero: program.
        logic        infoBlock;  // Target is the information block.
        logic        whole;      // Erase covers the main block too.
        logic [23:0] addr;
        logic [15:0] data;
    } flash_req_s;
endpackage

//--- flash_access_protection_ctrl.sv
// Purpose: Access gating, protection decode and write pipelining for program and data flash.
// Assumes: The array model outside performs the actual cell operation when a request fires.
// Notes:   One register port, one clock, no interrupts.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module flash_access_protection_ctrl
    import flash_access_pkg::*;
#(
    parameter int OP_LEN = OP_CYCLES        // Cycles per flash operation.
) (
    // Clock and reset.
    input  wire  logic        clock,
    input  wire  logic        reset,
    // Register port.
    input  wire  logic [3:0]  regAddr,
    input  wire  logic [15:0] regWdata,
    input  wire  logic        regWrite,
    input  wire  logic        regRead,
    output logic       [15:0] regRdata,
    // CPU main-block write and erase requests.
    input  wire  logic        cpuWrite,
    input  wire  logic [23:0] cpuAddr,
    input  wire  logic [15:0] cpuWdata,
    // Protection word as stored in the array.
    input  wire  logic [15:0] storedProtWord,
    // Information block read data from the arrays.
    input  wire  logic [15:0] progIbRdata,
    input  wire  logic [15:0] dataIbRdata,
    // Commands to the arrays.
    output flash_req_s        progReq,
    output flash_req_s        dataReq,
    // Protection outputs.
    output logic              debugReadBlock,
    output logic              cpuWriteBlock,
    output logic       [23:0] bootLast
);
    // Per-array pipeline: one running operation and one queued.
    typedef struct packed {
        logic        busy;
        logic        full;
        logic [15:0] count;
        flash_req_s  queued;
    } pipe_s;

    // All module state.
    typedef struct packed {
        logic [15:0] prog0Wren;
        logic [15:0] prog1Wren;
        logic [15:0] dataWren;
        logic [7:0]  progIbAddr;
        logic [7:0]  dataIbAddr;
        logic [1:0]  progCtrl;
        logic [1:0]  dataCtrl;
        logic [15:0] protWord;
        logic        protLoaded;
        pipe_s       progPipe;
        pipe_s       dataPipe;
        flash_req_s  progOut;
        flash_req_s  dataOut;
        logic [15:0] rdata;
    } state_s;

    state_s state;       // Registered state.
    state_s next_state;  // Next value.

    // Majority of three bits zero.
    function automatic logic majorityZero(input logic [2:0] f);
        majorityZero = ((~f[0] & ~f[1]) | (~f[0] & ~f[2]) | (~f[1] & ~f[2]));
    endfunction

    // Push a request into a pipeline; a busy pipe queues it and raises full.
    // A push while already full overwrites the queued request, so software polls full.
    function automatic pipe_s pipePush(input pipe_s p, input flash_req_s r,
                                       output flash_req_s issue);
        pipe_s q;
        q = p;
        issue = '0;
        if (!p.busy) begin
            q.busy  = 1'b1;
            q.count = 16'(OP_LEN);
            issue   = r;
        end else begin
            q.full   = 1'b1;
            q.queued = r;
        end
        pipePush = q;
    endfunction

    // Advance a pipeline by one cycle; a queued request starts when the current ends.
    function automatic pipe_s pipeStep(input pipe_s p, output flash_req_s issue);
        pipe_s q;
        q = p;
        issue = '0;
        if (p.busy) begin
            if (p.count > 16'h0001) begin
                q.count = p.count - 16'h0001;
            end else if (p.full) begin
                q.full   = 1'b0;
                q.count  = 16'(OP_LEN);
                issue    = p.queued;
                q.queued = '0;
            end else begin
                q.busy  = 1'b0;
                q.count = 16'h0000;
            end
        end
        pipeStep = q;
    endfunction

    // Decoded protection from the word latched after reset.
    logic        writeProt;
    logic        readProt;
    logic [23:0] bootEnd;     // First byte after the boot region.

    always_comb begin
        writeProt = majorityZero(state.protWord[WRP_LSB +: 3]);
        readProt  = majorityZero(state.protWord[RDP_LSB +: 3]);
        // Inverted field counts 2048-byte units; at most fifteen, so end is 77FFh.
        bootEnd   = {9'h000, ~state.protWord[BOOT_LSB +: 4], 11'h000};
    end

    // Main next-state logic.
    always_comb begin
        flash_req_s req;
        flash_req_s issueA;
        flash_req_s issueB;
        logic       inProg;
        logic       inData;
        logic       allowed;
        logic [3:0] sect;
        req     = '0;
        issueA  = '0;
        issueB  = '0;
        inProg  = 1'b0;
        inData  = 1'b0;
        allowed = 1'b0;
        sect    = 4'h0;
        next_state = state;
        next_state.progOut = '0;
        next_state.dataOut = '0;
        // Protection word is captured once after reset release only.
        // Latching once keeps a rewritten word from acting before the next reset.
        if (!state.protLoaded) begin
            next_state.protWord   = storedProtWord;
            next_state.protLoaded = 1'b1;
        end
        // Pipelines run independently so data flash works beside program fetches.
        next_state.progPipe = pipeStep(state.progPipe, issueA);
        next_state.dataPipe = pipeStep(state.dataPipe, issueB);
        if (issueA.valid) next_state.progOut = issueA;
        if (issueB.valid) next_state.dataOut = issueB;
        // CPU main-block write or erase.
        if (cpuWrite) begin
            inProg = (cpuAddr <= PROG_LAST);
            inData = (cpuAddr >= DATA_BASE) && (cpuAddr <= DATA_LAST);
            if (inProg) begin
                sect = cpuAddr[PROG_SECT_LSB +: 4];
                allowed = !writeProt && (cpuAddr >= bootEnd) &&
                          (cpuAddr[17] ? state.prog1Wren[sect] : state.prog0Wren[sect]);
                if (state.progCtrl[CTRL_MER]) begin
                    // A module erase needs every section and no boot area in the block.
                    allowed = !writeProt &&
                        (cpuAddr[17] ? (&state.prog1Wren)
                                     : ((&state.prog0Wren) && (bootEnd == 24'h000000)));
                end
            end else if (inData) begin
                sect = cpuAddr[DATA_SECT_LSB +: 4];
                allowed = !writeProt && state.dataWren[sect];
                if (state.dataCtrl[CTRL_MER]) allowed = !writeProt && (&state.dataWren);
            end
            req.valid = 1'b1;
            req.addr  = cpuAddr;
            req.data  = cpuWdata;
            req.erase = inProg ? state.progCtrl[CTRL_MER] : state.dataCtrl[CTRL_MER];
            req.whole = req.erase;
            // Anything blocked is simply never issued.
            if (allowed && inProg) begin
                next_state.progPipe = pipePush(next_state.progPipe, req, issueA);
                if (issueA.valid) next_state.progOut = issueA;
            end else if (allowed && inData) begin
                next_state.dataPipe = pipePush(next_state.dataPipe, req, issueB);
                if (issueB.valid) next_state.dataOut = issueB;
            end
        end
        // Register writes.
        if (regWrite) begin
            case (regAddr)
                OFS_PROG0_WREN:  next_state.prog0Wren  = regWdata;
                OFS_PROG1_WREN:  next_state.prog1Wren  = regWdata;
                OFS_DATA_WREN:   next_state.dataWren   = regWdata;
                OFS_PROG_IBADDR: next_state.progIbAddr = {regWdata[7:1], 1'b0};
                OFS_DATA_IBADDR: next_state.dataIbAddr = {1'b0, regWdata[6:1], 1'b0};
                OFS_PROG_CTRL:   next_state.progCtrl   = regWdata[1:0];
                OFS_DATA_CTRL:   next_state.dataCtrl   = regWdata[1:0];
                OFS_PROG_IBDATA: begin
                    // Block 0 is never written; block 1 follows the last section's enable.
                    req = '0;
                    req.valid     = 1'b1;
                    req.infoBlock = 1'b1;
                    req.addr      = {16'h0000, state.progIbAddr};
                    req.data      = regWdata;
                    req.erase     = state.progCtrl[CTRL_MER];
                    req.whole     = req.erase;
                    allowed = (state.progIbAddr >= IB1_FIRST) && !writeProt &&
                              state.prog1Wren[15] && (!req.erase || bootEnd == 24'h000000);
                    if (allowed) begin
                        next_state.progPipe = pipePush(next_state.progPipe, req, issueA);
                        if (issueA.valid) next_state.progOut = issueA;
                    end
                end
                OFS_DATA_IBDATA: begin
                    req = '0;
                    req.valid     = 1'b1;
                    req.infoBlock = 1'b1;
                    req.addr      = {16'h0000, state.dataIbAddr};
                    req.data      = regWdata;
                    req.erase     = state.dataCtrl[CTRL_MER];
                    req.whole     = req.erase;
                    if (!writeProt) begin
                        next_state.dataPipe = pipePush(next_state.dataPipe, req, issueB);
                        if (issueB.valid) next_state.dataOut = issueB;
                    end
                end
                default: ;
            endcase
        end
        // Register reads, answered in the next cycle.
        // Unmapped indices read as zero so software never sees stale data.
        next_state.rdata = 16'h0000;
        if (regRead) begin
            case (regAddr)
                OFS_PROG0_WREN:  next_state.rdata = state.prog0Wren;
                OFS_PROG1_WREN:  next_state.rdata = state.prog1Wren;
                OFS_DATA_WREN:   next_state.rdata = state.dataWren;
                OFS_PROG_IBADDR: next_state.rdata = {8'h00, state.progIbAddr};
                OFS_DATA_IBADDR: next_state.rdata = {8'h00, state.dataIbAddr};
                OFS_PROG_IBDATA: next_state.rdata = progIbRdata;
                OFS_DATA_IBDATA: next_state.rdata = dataIbRdata;
                OFS_PROG_STATUS: next_state.rdata = {14'h0000, state.progPipe.full,
                                                     state.progPipe.busy};
                OFS_DATA_STATUS: next_state.rdata = {14'h0000, state.dataPipe.full,
                                                     state.dataPipe.busy};
                OFS_PROT_WORD:   next_state.rdata = state.protWord;
                OFS_PROG_CTRL:   next_state.rdata = {14'h0000, state.progCtrl};
                OFS_DATA_CTRL:   next_state.rdata = {14'h0000, state.dataCtrl};
                default:         next_state.rdata = 16'h0000;
            endcase
        end
    end

    // State register; the erased protection word is the safe value until loaded.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state           <= '0;
            state.prog0Wren <= WREN_RESET;
            state.prog1Wren <= WREN_RESET;
            state.dataWren  <= WREN_RESET;
            state.protWord  <= PROT_ERASED;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from flip-flops, except decoded protection levels and bootLast.
    assign regRdata       = state.rdata;
    assign progReq        = state.progOut;
    assign dataReq        = state.dataOut;
    assign debugReadBlock = readProt;
    assign cpuWriteBlock  = writeProt;
    assign bootLast       = bootEnd - 24'h000001;

    // Checks.
    chk_boot_never_written: assert property (@(posedge clock) disable iff (reset)
        (cpuWrite && cpuAddr < bootEnd) |=> !progReq.valid || progReq.addr != $past(cpuAddr))
        else $error("boot region write was issued");
    chk_wren_after_reset: assert property (@(posedge clock) $fell(reset) |->
        state.prog0Wren == 16'h0000 && state.prog1Wren == 16'h0000 &&
        state.dataWren == 16'h0000)
        else $error("section enables not clear after reset");
    chk_global_block: assert property (@(posedge clock) disable iff (reset)
        writeProt && !state.progPipe.busy && !state.dataPipe.busy |=>
        !progReq.valid && !dataReq.valid)
        else $error("write issued under global protection");
    chk_section_gate: assert property (@(posedge clock) disable iff (reset)
        (cpuWrite && cpuAddr >= DATA_BASE && cpuAddr <= DATA_LAST && !state.dataCtrl[CTRL_MER]
         && !state.dataWren[cpuAddr[DATA_SECT_LSB +: 4]] && !state.dataPipe.busy) |=>
        !dataReq.valid)
        else $error("disabled data section accepted a write");
    chk_boot_limit: assert property (@(posedge clock) bootLast <= BOOT_MAX_LAST ||
        bootLast == 24'hffffff)
        else $error("boot region past maximum");
    chk_full_needs_busy: assert property (@(posedge clock) disable iff (reset)
        state.progPipe.full |-> state.progPipe.busy)
        else $error("full without busy");
    chk_full_clears: assert property (@(posedge clock) disable iff (reset)
        $rose(state.dataPipe.full) |-> ##[1:40] !state.dataPipe.full)
        else $error("pipeline full never cleared");
    chk_prot_stable: assert property (@(posedge clock) disable iff (reset)
        state.protLoaded && $past(state.protLoaded) |-> $stable(state.protWord))
        else $error("protection word changed without reset");
    chk_info0_ro: assert property (@(posedge clock) disable iff (reset)
        (regWrite && regAddr == OFS_PROG_IBDATA && state.progIbAddr < IB1_FIRST &&
         !state.progPipe.busy) |=> !progReq.valid)
        else $error("info block 0 written");
    // Coverage of the main scenarios: queued, concurrent, coupled and dropped requests.
    cov_data_write: cover property (@(posedge clock) disable iff (reset) dataReq.valid);
    cov_data_beside_prog: cover property (@(posedge clock) disable iff (reset)
        dataReq.valid && state.progPipe.busy);
    cov_boot_drop: cover property (@(posedge clock) disable iff (reset)
        cpuWrite && cpuAddr < bootEnd);
    cov_prog_full: cover property (@(posedge clock) disable iff (reset) state.progPipe.full);
    cov_info_erase: cover property (@(posedge clock) disable iff (reset)
        progReq.valid && progReq.infoBlock && progReq.erase);
endmodule
`default_nettype wire

//--- flash_access_protection_ctrl_tb.sv
// Purpose: Self-checking bench for the flash access protection controller.
// Assumes: Operation length shortened to four cycles.
// Notes:   Every scenario resets with its own stored protection word.
`timescale 1ns/1ns
`default_nettype none
module flash_access_protection_ctrl_tb
    import flash_access_pkg::*;
;
    localparam int OPL = 4;          // Shortened operation length.
    logic        clock = 1'b0;       // System clock.
    logic        reset = 1'b1;       // Asynchronous reset.
    logic [3:0]  regAddr = '0;       // Register port.
    logic [15:0] regWdata = '0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [15:0] regRdata;
    logic        cpuWrite = 1'b0;    // CPU request port.
    logic [23:0] cpuAddr = '0;
    logic [15:0] cpuWdata = '0;
    logic [15:0] protWord = 16'hffff; // Value stored in the array.
    logic [15:0] storedProtWord, progIbRdata, dataIbRdata;
    flash_req_s  progReq, dataReq;
    logic        debugReadBlock, cpuWriteBlock;
    logic [23:0] bootLast;
    int          num_errors = 0;     // Mismatches seen.
    int          checked = 0;        // Comparisons made.
    int          cycles = 0;         // Timeout counter.
    logic [31:0] p0, d0;             // Request counts before a step.
    logic [15:0] rd;                 // Last register read.

    flash_access_protection_ctrl #(.OP_LEN(OPL)) dut (.clock(clock), .reset(reset),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata),
        .storedProtWord(storedProtWord), .progIbRdata(progIbRdata),
        .dataIbRdata(dataIbRdata), .progReq(progReq), .dataReq(dataReq),
        .debugReadBlock(debugReadBlock), .cpuWriteBlock(cpuWriteBlock), .bootLast(bootLast));
    flash_array_model arrays (.clock(clock), .protIn(protWord), .progReq(progReq),
        .dataReq(dataReq), .storedProtWord(storedProtWord), .progIbRdata(progIbRdata),
        .dataIbRdata(dataIbRdata));

    // Free-running clock at 125 MHz.
    always #4 clock = ~clock;

    // A hang would stall the run forever, so cap it well past the expected length.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    // Compare a seen value with the expected one.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Reset with a new stored word; requests are legal from the second edge.
    task automatic do_reset(input logic [15:0] pw);
        @(posedge clock);
        protWord <= pw;
        reset    <= 1'b1;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // One-cycle register write.
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    // One-cycle register read; data stand only in the following cycle.
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        rd = regRdata;
    endtask

    // One CPU write pulse, then snapshot counts are compared by the caller.
    task automatic cpu_wr(input logic [23:0] a);
        @(posedge clock);
        cpuAddr  <= a;
        cpuWdata <= 16'h1234;
        cpuWrite <= 1'b1;
        @(posedge clock);
        cpuWrite <= 1'b0;
        repeat (OPL + 4) @(posedge clock);
    endtask

    task automatic snap();
        p0 = arrays.progCount;
        d0 = arrays.dataCount;
    endtask

    // Enables clear at reset and gate each section; unmapped index reads zero.
    task automatic test_sections();
        do_reset(16'hffff);
        reg_rd(OFS_PROG0_WREN); check("prog0 wren", rd, 32'h0);
        reg_rd(OFS_PROG1_WREN); check("prog1 wren", rd, 32'h0);
        reg_rd(OFS_DATA_WREN);  check("data wren", rd, 32'h0);
        reg_rd(4'hc); check("unmapped", rd, 32'h0);
        snap(); cpu_wr(24'h006000); check("no enable", arrays.progCount, p0);
        reg_wr(OFS_PROG0_WREN, 16'h0008);
        snap(); cpu_wr(24'h007ffe); check("sect3 hit", arrays.progCount, p0 + 1);
        check("sect3 addr", arrays.lastProg.addr, 32'h007ffe);
        snap(); cpu_wr(24'h008000); check("sect4 off", arrays.progCount, p0);
        reg_wr(OFS_PROG1_WREN, 16'h8000);
        snap(); cpu_wr(24'h03e000); check("blk1 top", arrays.progCount, p0 + 1);
        snap(); cpu_wr(24'h020000); check("blk1 low", arrays.progCount, p0);
        reg_wr(OFS_DATA_WREN, 16'h0002);
        snap(); cpu_wr(24'h0d0200); check("data s1", arrays.dataCount, d0 + 1);
        snap(); cpu_wr(24'h0d01fe); check("data s0", arrays.dataCount, d0);
        reg_wr(OFS_PROG0_WREN, 16'h0000);
        snap(); cpu_wr(24'h007ffe); check("cleared", arrays.progCount, p0);
        $display("test sections done");
    endtask

    // Largest boot area: writes inside dropped, first code byte accepted.
    task automatic test_boot();
        do_reset(16'hffe1);
        check("boot last", bootLast, 32'h0077ff);
        reg_wr(OFS_PROG0_WREN, 16'hffff);
        snap(); cpu_wr(24'h0077fe); check("boot write", arrays.progCount, p0);
        snap(); cpu_wr(24'h007800); check("code write", arrays.progCount, p0 + 1);
        do_reset(16'hfffe);
        check("boot none", bootLast, 32'hffffff);
        $display("test boot done");
    endtask

    // Majority-zero fields; writes blocked even with every block 0 and data enable set.
    task automatic test_global();
        do_reset(16'h3fff);
        check("wr block", cpuWriteBlock, 32'h1);
        check("rd free", debugReadBlock, 32'h0);
        reg_wr(OFS_PROG0_WREN, 16'hffff);
        reg_wr(OFS_DATA_WREN, 16'hffff);
        snap(); cpu_wr(24'h010000); check("glob prog", arrays.progCount, p0);
        snap(); cpu_wr(24'h0d0000); check("glob data", arrays.dataCount, d0);
        reg_wr(OFS_DATA_IBADDR, 16'h0010);
        snap(); reg_wr(OFS_DATA_IBDATA, 16'h0000);
        repeat (4) @(posedge clock);
        check("glob dinfo", arrays.dataCount, d0);
        do_reset(16'hebff);
        check("rd block", debugReadBlock, 32'h1);
        check("wr free", cpuWriteBlock, 32'h0);
        reg_rd(OFS_PROG_IBDATA); check("cpu read", rd, 32'ha5c3);
        $display("test global done");
    endtask

    // Back-to-back writes queue in both arrays; data runs beside program.
    task automatic test_pipe();
        do_reset(16'hffff);
        reg_wr(OFS_PROG0_WREN, 16'hffff);
        reg_wr(OFS_DATA_WREN, 16'hffff);
        snap();
        @(posedge clock);
        cpuAddr  <= 24'h0d0000;
        cpuWrite <= 1'b1;
        @(posedge clock);
        cpuAddr  <= 24'h0d0002;
        @(posedge clock);
        cpuAddr  <= 24'h000100;
        @(posedge clock);
        cpuAddr  <= 24'h000102;
        @(posedge clock);
        cpuWrite <= 1'b0;
        reg_rd(OFS_PROG_STATUS);
        check("busy full", rd[1:0], 32'h3);
        repeat (3 * OPL) @(posedge clock);
        check("both ops", arrays.progCount, p0 + 2);
        check("data ops", arrays.dataCount, d0 + 2);
        check("spacing", arrays.minGap >= OPL, 32'h1);
        reg_rd(OFS_PROG_STATUS);
        check("idle", rd[1:0], 32'h0);
        $display("test pipe done");
    endtask

    // Indirect information block access, writes and coupled erases.
    task automatic test_info();
        do_reset(16'hffff);
        reg_wr(OFS_PROG_IBADDR, 16'h007e);
        reg_rd(OFS_PROG_IBDATA); check("ib0 read", rd, 32'ha5c3);
        reg_rd(OFS_DATA_IBDATA); check("ib2 read", rd, 32'h3c5a);
        snap(); reg_wr(OFS_PROG_IBDATA, 16'h0000);
        repeat (4) @(posedge clock);
        check("ib0 write", arrays.progCount, p0);
        reg_wr(OFS_PROG1_WREN, 16'h8000);
        reg_wr(OFS_PROG_IBADDR, PROT_WORD_ADDR);
        snap(); reg_wr(OFS_PROG_IBDATA, 16'h3fff);
        repeat (OPL + 4) @(posedge clock);
        check("pw write", arrays.progCount, p0 + 1);
        check("pw info", arrays.lastProg.infoBlock, 32'h1);
        check("pw later", cpuWriteBlock, 32'h0);
        reg_wr(OFS_PROG1_WREN, 16'hffff);
        reg_wr(OFS_PROG_CTRL, 16'h0002);
        reg_wr(OFS_PROG_IBDATA, 16'h0000);
        repeat (OPL + 4) @(posedge clock);
        check("ib1 erase", arrays.lastProg.erase, 32'h1);
        check("ib1 whole", arrays.lastProg.whole, 32'h1);
        reg_wr(OFS_DATA_CTRL, 16'h0002);
        reg_wr(OFS_DATA_IBDATA, 16'h0000);
        repeat (OPL + 4) @(posedge clock);
        check("ib2 whole", arrays.lastData.whole, 32'h1);
        $display("test info done");
    endtask

    // Closing report and verdict.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        test_sections();
        test_boot();
        test_global();
        test_pipe();
        test_info();
        stop_test();
    end
endmodule
`default_nettype wire

//--- flash_array_model.sv
// Purpose: Behavioural flash arrays that face the access controller.
// Assumes: One request pulse starts one operation; no array content is kept.
// Notes:   Counts issued requests so the bench can see what got through.
`timescale 1ns/1ns
`default_nettype none
module flash_array_model
    import flash_access_pkg::*;
(
    // Clock.
    input  wire  logic        clock,
    // Protection word the bench wants stored.
    input  wire  logic [15:0] protIn,
    // Requests from the controller.
    input  wire  flash_req_s  progReq,
    input  wire  flash_req_s  dataReq,
    // Array read side.
    output logic       [15:0] storedProtWord,
    output logic       [15:0] progIbRdata,
    output logic       [15:0] dataIbRdata
);
    logic [31:0] progCount = '0;  // Program array operations seen.
    logic [31:0] dataCount = '0;  // Data array operations seen.
    flash_req_s  lastProg  = '0;  // Most recent program array request.
    flash_req_s  lastData  = '0;  // Most recent data array request.
    logic [31:0] progGap   = '0;  // Cycles since the last program request.
    logic [31:0] minGap    = 32'hffffffff; // Closest spacing of two program requests.

    // The word only changes in the array, so it is a plain level.
    assign storedProtWord = protIn;
    // Fixed patterns make a pass-through of the wrong block visible.
    assign progIbRdata = 16'ha5c3;
    assign dataIbRdata = 16'h3c5a;

    // Record each pulse; spacing shows whether a queued write waited its turn.
    always @(posedge clock) begin
        progGap <= progGap + 32'h1;
        if (progReq.valid === 1'b1) begin
            progCount <= progCount + 32'h1;
            lastProg  <= progReq;
            progGap   <= 32'h1;
            if (progGap < minGap) begin
                minGap <= progGap;
            end
        end
        if (dataReq.valid === 1'b1) begin
            dataCount <= dataCount + 32'h1;
            lastData  <= dataReq;
        end
    end
endmodule
`default_nettype wire
